/* hdl/ccc_regs.svh */
// Command codes, register offsets, field positions, values and timings
`ifndef CCC_REGS_SVH
`define CCC_REGS_SVH

`define CCC_CMD_GET_TOFS  16'h2318
`define CCC_CMD_SET_TOFS  16'h241D
`define CCC_CMD_SET_ALT   16'h2427
`define CCC_CMD_GET_ALT   16'h2322
`define CCC_CMD_SET_PRES  16'hE000
`define CCC_CMD_REFCAL    16'h362F
`define CCC_CMD_STOP      16'h3F86
`define CCC_CMD_START_PER 16'h21B1
`define CCC_CMD_START_LP  16'h21AC

`define CCC_REFCAL_BIAS   16'h8000
`define CCC_REFCAL_FAIL   16'hFFFF
`define CCC_BG_REF_PPM    16'h0190
`define CCC_ALT_RESET     16'h0000
`define CCC_CRC_POLY      8'h31
`define CCC_CRC_INIT      8'hFF

`define CCC_CLK_MHZ       50
`define CCC_T_CMD_US      1000
`define CCC_T_REFCAL_US   400000
`define CCC_T_STOP_US     500000

`define CCC_REG_CTRL      4'h0
`define CCC_REG_PARAM     4'h4
`define CCC_REG_RESP      4'h8
`define CCC_REG_STAT      4'hC
`define CCC_CTRL_PAR_BIT  16
`define CCC_CTRL_RSP_BIT  17
`define CCC_ST_BUSY       0
`define CCC_ST_DONE       1
`define CCC_ST_CRCERR     2
`define CCC_ST_NACK       3
`define CCC_ST_REFUSED    4

`endif

/* hdl/ccc_pkg.sv */
// Shared types and the word checksum
package ccc_pkg;
  `include "ccc_regs.svh"

  typedef enum logic [1:0] {DS_IDLE, DS_RECV, DS_BUSY, DS_READY} ccc_dev_state_t;
  typedef enum logic [2:0] {HS_IDLE, HS_SEND, HS_WAIT, HS_RDREQ,
                            HS_RDWAIT} ccc_host_state_t;

  // Checksum over one 16-bit word, high byte first
  function automatic logic [7:0] ccc_crc(input logic [15:0] w);
    logic [7:0] c;
    logic       fb;
    c = `CCC_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ w[i];
      c  = {c[6:0], 1'b0} ^ (fb ? `CCC_CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage

/* hdl/ccc_link_if.sv */
// Byte link between bus master and sensor command logic
`timescale 1ns/1ns
`default_nettype none
interface ccc_link_if;
  logic       hostValid;
  logic       hostStart;
  logic [7:0] hostByte;
  logic       hostRdReq;
  logic       devValid;
  logic       devNack;
  logic [7:0] devByte;

  modport dev (input hostValid, hostStart, hostByte, hostRdReq,
               output devValid, devNack, devByte);
  modport host (output hostValid, hostStart, hostByte, hostRdReq,
                input devValid, devNack, devByte);
endinterface
`default_nettype wire

/* hdl/ccc_device.sv */
// Sensor end: compensation and calibration command interpreter
//
// Contract
// - Offset read returns encoded offset word
// - Altitude write stores metres, done 1 ms
// - Altitude read returns stored metres
// - Altitude commands only while idle
// - Altitude volatile until saved elsewhere
// - Altitude defaults to zero after power-up
// - Pressure write stores hectopascal word
// - Pressure accepted during periodic measurement
// - Written pressure overrides altitude compensation
// - Background calibration reference is 400 ppm
// - Run over three minutes before recalibration; run time is not checked, one measurement since power-up with measuring low suffices
// - Stop, wait 500 ms, then recalibrate
// - Recalibration takes target, answers after 400 ms
// - Success answer is correction plus 0x8000
// - Failure answer is 0xFFFF
// - Fail when never measured since power-up
// - Configuration access only while idle
// - Nothing else within 500 ms of stop
`timescale 1ns/1ns
`default_nettype none
`include "ccc_regs.svh"
module ccc_device #(
  parameter int EXEC_CYC   = 16,
  parameter int REFCAL_CYC = 64
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  ccc_link_if.dev          link,
  input  wire logic [15:0] tempOffsetWord,
  input  wire logic        measuring,
  input  wire logic        measDone,
  input  wire logic [15:0] co2Ppm,
  input  wire logic        nvAltValid,
  input  wire logic [15:0] nvAltitude,
  output logic      [15:0] altitudeWord,
  output logic      [15:0] pressureWord,
  output logic             usePressure,
  output logic      [15:0] bgRefPpm,
  output logic             refcalDone,
  output logic      [15:0] refcalWord
);
  import ccc_pkg::*;

  ccc_pkg::ccc_dev_state_t stateFf;
  logic [39:0] bufFf;
  logic [2:0]  cntFf;
  logic [31:0] timerFf;
  logic [23:0] respFf;
  logic        hasRespFf;
  logic [1:0]  rdIdxFf;
  logic        measOnceFf;
  logic        nvLoadedFf;
  logic [15:0] altFf;
  logic [15:0] presFf;
  logic        usePresFf;
  logic [15:0] bgRefFf;
  logic        refDoneFf;
  logic [15:0] refWordFf;
  logic        devValidFf;
  logic        devNackFf;
  logic [7:0]  devByteFf;

  wire         busy     = (stateFf == DS_BUSY);
  wire         byteIn   = link.hostValid && !busy;
  wire [39:0]  nxtBuf   = {bufFf[31:0], link.hostByte};
  wire [2:0]   nxtCnt   = link.hostStart ? 3'h1 : cntFf + 3'h1;
  wire [15:0]  cmdShort = nxtBuf[15:0];
  wire [15:0]  cmdLong  = nxtBuf[39:24];
  wire [15:0]  parWord  = nxtBuf[23:8];
  wire         crcOk    = (ccc_crc(parWord) == nxtBuf[7:0]);
  wire         shortIsWr = (cmdShort == `CCC_CMD_SET_ALT) ||
                           (cmdShort == `CCC_CMD_SET_PRES) ||
                           (cmdShort == `CCC_CMD_REFCAL);
  wire         longIsWr  = (cmdLong == `CCC_CMD_SET_ALT) ||
                           (cmdLong == `CCC_CMD_SET_PRES) ||
                           (cmdLong == `CCC_CMD_REFCAL);
  wire         fireShort = byteIn && (nxtCnt == 3'h2) && !shortIsWr;
  wire         fireLong  = byteIn && (nxtCnt == 3'h5) && longIsWr &&
                           crcOk;
  wire [15:0]  execCmd   = fireLong ? cmdLong : cmdShort;
  wire         fire      = fireShort || fireLong;
  wire         isGetOfs  = (execCmd == `CCC_CMD_GET_TOFS);
  wire         isGetAlt  = (execCmd == `CCC_CMD_GET_ALT);
  wire         isSetAlt  = fireLong && (cmdLong == `CCC_CMD_SET_ALT);
  wire         isSetPres = fireLong && (cmdLong == `CCC_CMD_SET_PRES);
  wire         isRefcal  = fireLong && (cmdLong == `CCC_CMD_REFCAL);
  wire         refcalOk  = measOnceFf && !measuring;
  wire [15:0]  refCorr   = parWord - co2Ppm;
  wire [15:0]  refWord   = refcalOk ? refCorr + `CCC_REFCAL_BIAS
                                    : `CCC_REFCAL_FAIL;
  wire [15:0]  respWord  = isGetOfs ? tempOffsetWord
                         : isGetAlt ? altFf
                         : refWord;
  wire         respCmd   = fireShort && (isGetOfs || isGetAlt);
  wire         execResp  = respCmd || isRefcal;
  wire [31:0]  execTime  = isRefcal ? REFCAL_CYC : EXEC_CYC;
  wire         rdOk      = (stateFf == DS_READY) && hasRespFf &&
                           (rdIdxFf != 2'h3);
  wire [7:0]   rdByte    = (rdIdxFf == 2'h0) ? respFf[23:16]
                         : (rdIdxFf == 2'h1) ? respFf[15:8]
                         : respFf[7:0];

  // Link state and response path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateFf   <= DS_IDLE;
      bufFf     <= 40'h00_0000_0000;
      cntFf     <= 3'h0;
      timerFf   <= 32'h0000_0000;
      respFf    <= 24'h00_0000;
      hasRespFf <= 1'b0;
      rdIdxFf   <= 2'h0;
    end else if (ce) begin
      if (byteIn) begin
        bufFf <= nxtBuf;
        cntFf <= nxtCnt;
      end
      if (link.hostRdReq && rdOk) begin
        rdIdxFf <= rdIdxFf + 2'h1;
      end
      case (stateFf)
        DS_IDLE, DS_RECV, DS_READY: begin
          if (fire) begin
            stateFf   <= DS_BUSY;
            timerFf   <= execTime;
            hasRespFf <= execResp;
            respFf    <= {respWord, ccc_crc(respWord)};
            rdIdxFf   <= 2'h0;
          end else if (byteIn && link.hostStart) begin
            stateFf   <= DS_RECV;
            hasRespFf <= 1'b0;
          end
        end
        DS_BUSY: begin
          if (timerFf <= 32'h0000_0001) begin
            stateFf <= DS_READY;
          end else begin
            timerFf <= timerFf - 32'h0000_0001;
          end
        end
        default: stateFf <= DS_IDLE;
      endcase
    end
  end

  // Stored settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      measOnceFf <= 1'b0;
      nvLoadedFf <= 1'b0;
      altFf      <= `CCC_ALT_RESET;
      presFf     <= 16'h0000;
      usePresFf  <= 1'b0;
      bgRefFf    <= `CCC_BG_REF_PPM;
      refDoneFf  <= 1'b0;
      refWordFf  <= 16'h0000;
    end else if (ce) begin
      refDoneFf <= isRefcal;
      if (measDone) begin
        measOnceFf <= 1'b1;
      end
      if (!nvLoadedFf) begin
        nvLoadedFf <= 1'b1;
        if (nvAltValid) begin
          altFf <= nvAltitude;
        end
      end
      if (isSetAlt) begin
        altFf <= parWord;
      end
      if (isSetPres) begin
        presFf    <= parWord;
        usePresFf <= 1'b1;
      end
      if (isRefcal) begin
        refWordFf <= refWord;
      end
    end
  end

  // Byte answers to read requests
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      devValidFf <= 1'b0;
      devNackFf  <= 1'b0;
      devByteFf  <= 8'h00;
    end else if (ce) begin
      devValidFf <= link.hostRdReq && rdOk;
      devNackFf  <= link.hostRdReq && !rdOk;
      if (link.hostRdReq && rdOk) begin
        devByteFf <= rdByte;
      end
    end
  end

  assign link.devValid = devValidFf;
  assign link.devNack  = devNackFf;
  assign link.devByte  = devByteFf;
  assign altitudeWord  = altFf;
  assign pressureWord  = presFf;
  assign usePressure   = usePresFf;
  assign bgRefPpm      = bgRefFf;
  assign refcalDone    = refDoneFf;
  assign refcalWord    = refWordFf;
endmodule
`default_nettype wire

/* hdl/ccc_host.sv */
// Bus master end: AXI4-Lite command registers driving the byte link
`timescale 1ns/1ns
`default_nettype none
`include "ccc_regs.svh"
module ccc_host #(
  parameter int CMD_WAIT_CYC    = `CCC_T_CMD_US * `CCC_CLK_MHZ,
  parameter int REFCAL_WAIT_CYC = `CCC_T_REFCAL_US * `CCC_CLK_MHZ,
  parameter int STOP_WAIT_CYC   = `CCC_T_STOP_US * `CCC_CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  ccc_link_if.host         link,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import ccc_pkg::*;

  ccc_pkg::ccc_host_state_t stateFf;
  logic        awHeldFf, wHeldFf, awreadyFf, wreadyFf, bvalidFf, arreadyFf;
  logic        rvalidFf;
  logic [1:0]  brespFf, rrespFf;
  logic [3:0]  awAddrFf;
  logic [31:0] wDataFf, rdataFf;
  logic [15:0] cmdFf, paramFf, respFf;
  logic        wantRespFf, measRunFf;
  logic        doneFf, crcErrFf, nackFf, refusedFf;
  logic [39:0] sendFf;
  logic [2:0]  idxFf, lastFf;
  logic [31:0] timerFf;
  logic [23:0] rxFf;
  logic        hValidFf, hStartFf, hRdReqFf;
  logic [7:0]  hByteFf;

  wire        awTake  = awvalid && awreadyFf;
  wire        wTake   = wvalid && wreadyFf;
  wire        awHave  = awHeldFf || awTake;
  wire        wHave   = wHeldFf || wTake;
  wire        wrDo    = awHave && wHave && !bvalidFf;
  wire [3:0]  wAddr   = awHeldFf ? awAddrFf : awaddr;
  wire [31:0] wData   = wHeldFf ? wDataFf : wdata;
  wire        nxtAwH  = awHave && !wrDo;
  wire        nxtWH   = wHave && !wrDo;
  wire        nxtBv   = wrDo || (bvalidFf && !bready);
  wire        wMapped = (wAddr == `CCC_REG_CTRL) || (wAddr == `CCC_REG_PARAM)
                     || (wAddr == `CCC_REG_STAT);
  wire        idle    = (stateFf == HS_IDLE);
  wire        go      = wrDo && (wAddr == `CCC_REG_CTRL) && idle;
  wire        wrPar   = wrDo && (wAddr == `CCC_REG_PARAM) && wstrb[0];
  wire        wrStat  = wrDo && (wAddr == `CCC_REG_STAT);
  wire [15:0] goCmd   = wData[15:0];
  wire        goPar   = wData[`CCC_CTRL_PAR_BIT];
  wire        cfgCmd  = (goCmd == `CCC_CMD_GET_TOFS) ||
                        (goCmd == `CCC_CMD_SET_TOFS) ||
                        (goCmd == `CCC_CMD_SET_ALT) ||
                        (goCmd == `CCC_CMD_GET_ALT) ||
                        (goCmd == `CCC_CMD_REFCAL);
  wire        refuse  = go && measRunFf && cfgCmd;
  wire        start   = go && !refuse;
  wire [31:0] waitCyc = (cmdFf == `CCC_CMD_REFCAL) ? REFCAL_WAIT_CYC
                      : (cmdFf == `CCC_CMD_STOP) ? STOP_WAIT_CYC
                      : CMD_WAIT_CYC;
  wire        rxDone  = (stateFf == HS_RDWAIT) && link.devValid &&
                        (idxFf == 3'h2);
  wire [23:0] rxWord  = {rxFf[15:0], link.devByte};
  wire        finish  = rxDone || ((stateFf == HS_RDWAIT) && link.devNack)
                     || ((stateFf == HS_WAIT) && (timerFf <= 32'h1)
                         && !wantRespFf);
  wire        arTake  = arvalid && arreadyFf;
  wire        nxtRv   = arTake || (rvalidFf && !rready);
  wire [31:0] statWord = {27'h000_0000, refusedFf, nackFf, crcErrFf, doneFf,
                          !idle};
  wire [31:0] rdWord  = (araddr == `CCC_REG_CTRL) ?
                          {14'h0000, wantRespFf, 1'b0, cmdFf}
                      : (araddr == `CCC_REG_PARAM) ? {16'h0000, paramFf}
                      : (araddr == `CCC_REG_RESP) ? {16'h0000, respFf}
                      : statWord;
  wire        rMapped = (araddr == `CCC_REG_CTRL) ||
                        (araddr == `CCC_REG_PARAM) ||
                        (araddr == `CCC_REG_RESP) || (araddr == `CCC_REG_STAT);

  // AXI4-Lite slave handshakes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeldFf  <= 1'b0;
      wHeldFf   <= 1'b0;
      awreadyFf <= 1'b0;
      wreadyFf  <= 1'b0;
      bvalidFf  <= 1'b0;
      brespFf   <= 2'h0;
      awAddrFf  <= 4'h0;
      wDataFf   <= 32'h0000_0000;
      arreadyFf <= 1'b0;
      rvalidFf  <= 1'b0;
      rrespFf   <= 2'h0;
      rdataFf   <= 32'h0000_0000;
    end else if (ce) begin
      awHeldFf  <= nxtAwH;
      wHeldFf   <= nxtWH;
      awreadyFf <= !nxtAwH && !nxtBv;
      wreadyFf  <= !nxtWH && !nxtBv;
      bvalidFf  <= nxtBv;
      arreadyFf <= !nxtRv;
      rvalidFf  <= nxtRv;
      if (awTake) begin
        awAddrFf <= awaddr;
      end
      if (wTake) begin
        wDataFf <= wdata;
      end
      if (wrDo) begin
        brespFf <= wMapped ? 2'h0 : 2'h2;
      end
      if (arTake) begin
        rdataFf <= rMapped ? rdWord : 32'h0000_0000;
        rrespFf <= rMapped ? 2'h0 : 2'h2;
      end
    end
  end

  // Command sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateFf    <= HS_IDLE;
      cmdFf      <= 16'h0000;
      paramFf    <= 16'h0000;
      respFf     <= 16'h0000;
      wantRespFf <= 1'b0;
      measRunFf  <= 1'b0;
      sendFf     <= 40'h00_0000_0000;
      idxFf      <= 3'h0;
      lastFf     <= 3'h0;
      timerFf    <= 32'h0000_0000;
      rxFf       <= 24'h00_0000;
      hValidFf   <= 1'b0;
      hStartFf   <= 1'b0;
      hRdReqFf   <= 1'b0;
      hByteFf    <= 8'h00;
    end else if (ce) begin
      hValidFf <= 1'b0;
      hStartFf <= 1'b0;
      hRdReqFf <= 1'b0;
      if (wrPar) begin
        paramFf <= wData[15:0];
      end
      case (stateFf)
        HS_IDLE: begin
          if (start) begin
            stateFf    <= HS_SEND;
            cmdFf      <= goCmd;
            wantRespFf <= wData[`CCC_CTRL_RSP_BIT];
            sendFf     <= {goCmd, paramFf, ccc_crc(paramFf)};
            lastFf     <= goPar ? 3'h4 : 3'h1;
            idxFf      <= 3'h0;
          end
        end
        HS_SEND: begin
          hValidFf <= 1'b1;
          hStartFf <= (idxFf == 3'h0);
          hByteFf  <= sendFf[39:32];
          sendFf   <= {sendFf[31:0], 8'h00};
          idxFf    <= idxFf + 3'h1;
          if (idxFf == lastFf) begin
            stateFf <= HS_WAIT;
            timerFf <= waitCyc;
          end
        end
        HS_WAIT: begin
          if (timerFf > 32'h1) begin
            timerFf <= timerFf - 32'h1;
          end else if (wantRespFf) begin
            stateFf <= HS_RDREQ;
            idxFf   <= 3'h0;
          end else begin
            stateFf <= HS_IDLE;
          end
          if (timerFf <= 32'h1) begin
            if (cmdFf == `CCC_CMD_STOP) begin
              measRunFf <= 1'b0;
            end else if ((cmdFf == `CCC_CMD_START_PER) ||
                         (cmdFf == `CCC_CMD_START_LP)) begin
              measRunFf <= 1'b1;
            end
          end
        end
        HS_RDREQ: begin
          hRdReqFf <= 1'b1;
          stateFf  <= HS_RDWAIT;
        end
        HS_RDWAIT: begin
          if (link.devNack) begin
            stateFf <= HS_IDLE;
          end else if (link.devValid) begin
            rxFf  <= rxWord;
            idxFf <= idxFf + 3'h1;
            if (idxFf == 3'h2) begin
              stateFf <= HS_IDLE;
              respFf  <= rxWord[23:8];
            end else begin
              stateFf <= HS_RDREQ;
            end
          end
        end
        default: stateFf <= HS_IDLE;
      endcase
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      doneFf    <= 1'b0;
      crcErrFf  <= 1'b0;
      nackFf    <= 1'b0;
      refusedFf <= 1'b0;
    end else if (ce) begin
      doneFf    <= finish || (doneFf && !(wrStat && wData[`CCC_ST_DONE]));
      crcErrFf  <= (rxDone && (ccc_crc(rxWord[23:8]) != rxWord[7:0])) ||
                   (crcErrFf && !(wrStat && wData[`CCC_ST_CRCERR]));
      nackFf    <= ((stateFf == HS_RDWAIT) && link.devNack) ||
                   (nackFf && !(wrStat && wData[`CCC_ST_NACK]));
      refusedFf <= refuse ||
                   (refusedFf && !(wrStat && wData[`CCC_ST_REFUSED]));
    end
  end

  assign awready        = awreadyFf;
  assign wready         = wreadyFf;
  assign bvalid         = bvalidFf;
  assign bresp          = brespFf;
  assign arready        = arreadyFf;
  assign rvalid         = rvalidFf;
  assign rresp          = rrespFf;
  assign rdata          = rdataFf;
  assign link.hostValid = hValidFf;
  assign link.hostStart = hStartFf;
  assign link.hostByte  = hByteFf;
  assign link.hostRdReq = hRdReqFf;
endmodule
`default_nettype wire

/* dv/ccc_asserts.sv */
// Link protocol checker for the sensor byte link
`timescale 1ns/1ns
`default_nettype none
module ccc_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       hostValid,
  input wire logic       hostStart,
  input wire logic [7:0] hostByte,
  input wire logic       hostRdReq,
  input wire logic       devValid,
  input wire logic       devNack,
  input wire logic [7:0] devByte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ONE_ANSWER: assert property (
    !(devValid && devNack)) else $error("data and nack together");
  AST_VALID_CAUSE: assert property (
    devValid |-> $past(hostRdReq)) else $error("data without request");
  AST_NACK_CAUSE: assert property (
    devNack |-> $past(hostRdReq)) else $error("nack without request");
  AST_RDREQ_ANSWER: assert property (
    hostRdReq |=> devValid || devNack) else $error("request unanswered");
  AST_START_VALID: assert property (
    hostStart |-> hostValid) else $error("start without byte");
  AST_START_NEXT: assert property (
    hostStart |=> hostValid && !hostStart) else $error("command cut short");
  AST_CONSEC: assert property (
    hostValid && !hostStart |-> $past(hostValid))
    else $error("gap inside a frame");
  AST_BYTE_HOLD: assert property (
    $changed(devByte) |-> devValid) else $error("read byte changed alone");

  cover property (hostStart && hostByte == 8'h36);
  cover property (devValid);
  cover property (devNack);
endmodule
`default_nettype wire

/* dv/compensation_calibration_cmds_tb.sv */
// Self-checking bench for both ends of the sensor command link
`timescale 1ns/1ns
`default_nettype none
`include "ccc_regs.svh"
module compensation_calibration_cmds_tb;
  logic        clk;
  logic        rst_n;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] tempOffsetWord;
  logic        measuring;
  logic        measDone;
  logic [15:0] co2Ppm;
  logic [15:0] altitudeWord;
  logic [15:0] pressureWord;
  logic        usePressure;
  logic [15:0] bgRefPpm;
  logic        refcalDone;
  logic [15:0] refcalWord;
  logic        nvAltValid;
  logic [15:0] nvAltitude;
  logic [1:0]  b;
  logic [15:0] rnd;
  logic [15:0] w;
  logic [31:0] s;
  logic [1:0]  r;
  int          fails;
  int          checks;
  int          cyc;
  int          altM;
  int          expM;
  int          refPulses;

  ccc_link_if link ();

  ccc_device i_ccc_device (.clk(clk), .rst_n(rst_n), .ce(1'h1),
    .link(link), .tempOffsetWord(tempOffsetWord), .measuring(measuring),
    .measDone(measDone), .co2Ppm(co2Ppm), .nvAltValid(nvAltValid),
    .nvAltitude(nvAltitude), .altitudeWord(altitudeWord),
    .pressureWord(pressureWord), .usePressure(usePressure),
    .bgRefPpm(bgRefPpm), .refcalDone(refcalDone), .refcalWord(refcalWord));

  ccc_host #(.CMD_WAIT_CYC(20), .REFCAL_WAIT_CYC(80), .STOP_WAIT_CYC(40))
  i_ccc_host (.clk(clk), .rst_n(rst_n), .ce(1'h1), .link(link),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  ccc_asserts i_ccc_asserts (.clk(clk), .rst_n(rst_n),
    .hostValid(link.hostValid), .hostStart(link.hostStart),
    .hostByte(link.hostByte), .hostRdReq(link.hostRdReq),
    .devValid(link.devValid), .devNack(link.devNack),
    .devByte(link.devByte));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    b = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] rr);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask

  // Sends one command, waits for completion, returns the response word
  task automatic cmd(input logic [15:0] c, input logic [15:0] p,
                     input logic hp, output logic [15:0] resp);
    if (hp) wr(4'h4, {16'h0000, p});
    wr(4'h0, {14'h0000, 1'h1, hp, c});
    do rd(4'hC, s, r); while (s[1] !== 1'h1);
    chk("crcerr", 16'h0000, {15'h0000, s[2]});
    wr(4'hC, 32'h0000001E);
    rd(4'h8, s, r);
    resp = s[15:0];
  endtask

  // Configuration command while measuring: refused, nothing started
  task automatic refchk(input logic [15:0] c);
    wr(`CCC_REG_CTRL, {14'h0000, 1'h1, 1'h0, c});
    chk("brespcfg", 16'h0000, {14'h0000, b});
    rd(`CCC_REG_STAT, s, r);
    chk("refused", 16'h0010, s[15:0]);
    wr(`CCC_REG_STAT, 32'h0000001E);
  endtask

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  // Counts recalibration pulses seen on the sensor end
  always @(posedge clk) begin
    refPulses <= refPulses + ((refcalDone === 1'h1) ? 1 : 0);
  end

  initial begin
    rst_n = 1'h0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, measuring, measDone} = '0;
    nvAltValid = 1'h0;
    nvAltitude = 16'h079E;
    wstrb = 4'hF;
    tempOffsetWord = 16'h0912;
    co2Ppm = 16'h01F4;
    rnd = 16'h0027;
    altM = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    chk("bgref", 16'h0190, bgRefPpm);
    chk("alt0", 16'h0000, altitudeWord);
    chk("usep0", 16'h0000, {15'h0000, usePressure});
    cmd(`CCC_CMD_GET_ALT, 16'h0000, 1'h0, w);
    chk("altrd0", altM[15:0], w);
    cmd(`CCC_CMD_REFCAL, 16'h01E0, 1'h1, w);
    chk("refnomeas", 16'hFFFF, w);
    chk("refword", 16'hFFFF, refcalWord);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      altM = rnd;
      cmd(`CCC_CMD_SET_ALT, rnd, 1'h1, w);
      chk("altwr", altM[15:0], altitudeWord);
      cmd(`CCC_CMD_GET_ALT, 16'h0000, 1'h0, w);
      chk("altrd", altM[15:0], w);
      rnd = lfsr(rnd);
      tempOffsetWord <= rnd;
      cmd(`CCC_CMD_GET_TOFS, 16'h0000, 1'h0, w);
      chk("tofs", rnd, w);
    end
    cmd(`CCC_CMD_START_PER, 16'h0000, 1'h0, w);
    measuring <= 1'h1;
    measDone <= 1'h1;
    @(posedge clk);
    measDone <= 1'h0;
    rnd = lfsr(rnd);
    cmd(`CCC_CMD_SET_PRES, rnd, 1'h1, w);
    chk("pres", rnd, pressureWord);
    chk("usep", 16'h0001, {15'h0000, usePressure});
    chk("altkeep", altM[15:0], altitudeWord);
    refchk(`CCC_CMD_GET_ALT);
    cmd(`CCC_CMD_STOP, 16'h0000, 1'h0, w);
    measuring <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      co2Ppm <= rnd;
      expM = -int'(rnd);
      rnd = lfsr(rnd);
      expM = (expM + int'(rnd) + 32'h00008000) & 32'h0000FFFF;
      cmd(`CCC_CMD_REFCAL, rnd, 1'h1, w);
      chk("refcal", expM[15:0], w);
      chk("refword", expM[15:0], refcalWord);
    end
    cmd(`CCC_CMD_START_LP, 16'h0000, 1'h0, w);
    refchk(`CCC_CMD_GET_TOFS);
    cmd(`CCC_CMD_STOP, 16'h0000, 1'h0, w);
    @(posedge clk);
    rnd = lfsr(rnd);
    nvAltitude <= rnd;
    nvAltValid <= 1'h1;
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    chk("altnv", rnd, altitudeWord);
    chk("usepr", 16'h0000, {15'h0000, usePressure});
    cmd(`CCC_CMD_GET_ALT, 16'h0000, 1'h0, w);
    chk("altnvrd", rnd, w);
    rd(4'h1, s, r);
    chk("unmapped", 16'h0002, {14'h0000, r});
    wr(4'h1, 32'h0000_0000);
    chk("brespun", 16'h0002, {14'h0000, b});
    chk("refpulse", 16'h0003, refPulses[15:0]);
    test_done();
  end
endmodule
`default_nettype wire
